/* pifeb_pkg.sv */
package pifeb_pkg;

  // register addresses as printed, one byte per address
  localparam logic [11:0] OFF_REQ0 = 12'h70c;
  localparam logic [11:0] OFF_REQ1 = 12'h70d;
  localparam logic [11:0] OFF_REQ2 = 12'h70e;
  localparam logic [11:0] OFF_EN0 = 12'h716;
  localparam logic [11:0] OFF_EN1 = 12'h717;
  localparam logic [11:0] OFF_EN2 = 12'h718;
  localparam logic [11:0] OFF_RX_DATA = 12'h720;
  localparam logic [11:0] OFF_TX_DATA = 12'h721;
  localparam logic [11:0] OFF_STATUS = 12'h722;

  // request register 0
  localparam int BIT_TIMER0 = 5;
  localparam int BIT_CHANGE = 4;
  localparam int BIT_EXT_PIN = 0;
  // request register 1
  localparam int BIT_CAPCMP1 = 7;
  localparam int BIT_TIMER2 = 6;
  localparam int BIT_TIMER1 = 5;
  localparam int BIT_SERIAL_RX = 4;
  localparam int BIT_SERIAL_TX = 3;
  localparam int BIT_BUS_COLL = 2;
  localparam int BIT_SYNC_SER = 1;
  localparam int BIT_CONVERTER = 0;
  // request register 2
  localparam int BIT_CAPCMP2 = 7;
  localparam int BIT_NVM_DONE = 6;
  localparam int BIT_T1_GATE = 5;
  // status register
  localparam int BIT_ST_IRQ = 0;
  localparam int BIT_ST_PEND0 = 1;
  localparam int BIT_ST_PEND12 = 2;
  localparam int BIT_ST_SHIFT_EMPTY = 3;

  // implemented bits and the software-clearable sticky bits
  localparam logic [7:0] IMPL_MASK_0 = 8'h31;
  localparam logic [7:0] IMPL_MASK_1 = 8'hff;
  localparam logic [7:0] IMPL_MASK_2 = 8'he0;
  localparam logic [7:0] STICKY_MASK_0 = 8'h21;
  localparam logic [7:0] STICKY_MASK_1 = 8'he7;
  localparam logic [7:0] STICKY_MASK_2 = 8'he0;

  localparam logic [7:0] RESET_REQ = 8'h00;
  localparam logic [7:0] RESET_EN = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  localparam int PIN_CHANGE_W = 24;

  typedef enum logic [3:0] {
    CCP_OFF = 4'b0001,
    CCP_CAPTURE = 4'b0010,
    CCP_COMPARE = 4'b0100,
    CCP_PWM = 4'b1000
  } pifeb_ccp_mode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pifeb_bus_t;

  typedef struct packed {
    pifeb_ccp_mode_t mode;
    logic capture;
    logic compare;
    logic pwm_level;
  } pifeb_ccp_t;

  typedef struct packed {
    logic timer0;
    logic ext_pin;
    logic timer2;
    logic timer1;
    logic bus_collision;
    logic sync_serial;
    logic converter;
    logic nvm_done;
  } pifeb_evt_t;

  typedef struct packed {
    logic rx_not_empty;
    logic tx_buf_empty;
    logic tx_shift_empty;
    logic [7:0] rx_data;
  } pifeb_uart_t;

endpackage : pifeb_pkg

/* pifeb_flag_reg.sv */
`timescale 1ns/100ps
module pifeb_flag_reg #(
  parameter logic [7:0] STICKY = 8'h00
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] set_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] flags_out
);
  import pifeb_pkg::*;

  logic [7:0] flags_r;
  logic [7:0] flags_nxt;

  // a set in the same cycle as a clearing write wins, so no event is lost
  always_comb begin
    flags_nxt = STICKY & (set_in | (wr_in ? wdata_in : flags_r));
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flags_r <= RESET_REQ;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_out = flags_r;

endmodule : pifeb_flag_reg

/* pifeb_bank.sv */
// Notes on behaviour
// R1 - capcmp1_flag sets per mode on capture, compare match or PWM trailing edge; sticky
// R2 - capcmp2_flag behaves the same per mode; only software clears it
// R3 - timer2_flag set by hardware event, stays until software writes it clear
// R4 - timer1_flag set by hardware event, cleared only by software write
// R5 - serial_rx_flag read-only, high while the receive buffer holds data
// R6 - reading serial_rx_data clears serial_rx_flag; writes cannot clear it
// R7 - serial_tx_flag read-only, high while transmit buffer is empty
// R8 - serial_tx_flag clears only on loading serial_tx_data; not transmission-complete
// R9 - bus_collision_flag sets on detected collision, sticky until software clears
// R10 - sync_serial_flag sets on port event, cleared only by software
// R11 - converter_flag sets on converter event, holds until software clears
// R12 - nvm_done_flag sets when memory operation completes, sticky
// R13 - timer1_gate_flag sets when gate goes inactive, reads 0 only after clear
// R14 - flags set regardless of enable bits and global gate
// R15 - software should clear a pending flag before enabling it
// R16 - enable register 1 and 2 sources need periph_irq_gate as well
// R17 - enable register 0 sources need only global_irq_gate
// R18 - change_detect_flag is OR of pin_change_flags; clears when all clear
// R19 - pending is flag AND same-position enable; all pending ORed to core
`timescale 1ns/100ps
module pifeb_bank (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire pifeb_pkg::pifeb_bus_t bus_in,
  output logic [7:0] rd_data_out,
  input wire pifeb_pkg::pifeb_ccp_t ccp1_in,
  input wire pifeb_pkg::pifeb_ccp_t ccp2_in,
  input wire pifeb_pkg::pifeb_evt_t evt_in,
  input wire logic timer1_gate_active_in,
  input wire logic [pifeb_pkg::PIN_CHANGE_W-1:0] pin_change_flags_in,
  input wire pifeb_pkg::pifeb_uart_t uart_in,
  output logic rx_pop_out,
  output logic tx_load_out,
  output logic [7:0] tx_data_out,
  input wire logic global_irq_gate_in,
  input wire logic periph_irq_gate_in,
  output logic irq_out,
  output logic [7:0] pending0_out,
  output logic [7:0] pending1_out,
  output logic [7:0] pending2_out
);
  import pifeb_pkg::*;

  // address decode shared by reads and writes
  function automatic logic hit(input pifeb_bus_t b, input logic [11:0] off);
    hit = (b.addr == off);
  endfunction : hit

  // selects the event that counts for the unit's present mode
  function automatic logic ccp_event(input pifeb_ccp_t c, input logic pwm_prev);
    case (c.mode)
      CCP_CAPTURE: ccp_event = c.capture;
      CCP_COMPARE: ccp_event = c.compare;
      CCP_PWM: ccp_event = pwm_prev & ~c.pwm_level;
      default: ccp_event = 1'b0;
    endcase
  endfunction : ccp_event

  logic wr_req0;
  logic wr_req1;
  logic wr_req2;
  logic rd_rx_data;
  logic wr_tx_data;

  logic [7:0] enable0_r;
  logic [7:0] enable1_r;
  logic [7:0] enable2_r;

  logic pwm1_prev_r;
  logic pwm2_prev_r;
  logic gate_prev_r;
  logic capcmp1_set;
  logic capcmp2_set;
  logic gate_set;

  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] sticky0;
  logic [7:0] sticky1;
  logic [7:0] sticky2;

  logic rx_pop_hold_r;
  logic tx_load_hold_r;
  logic serial_rx_flag;
  logic serial_tx_flag;
  logic change_detect_flag;

  logic [7:0] request0;
  logic [7:0] request1;
  logic [7:0] request2;
  logic [7:0] pend0;
  logic [7:0] pend1;
  logic [7:0] pend2;
  logic any_pend0;
  logic any_pend12;
  logic irq_nxt;
  logic irq_r;

  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic [7:0] tx_data_r;

  // write decode; request bits that are read-only ignore the write
  always_comb begin
    wr_req0 = bus_in.wr & hit(bus_in, OFF_REQ0);
    wr_req1 = bus_in.wr & hit(bus_in, OFF_REQ1);
    wr_req2 = bus_in.wr & hit(bus_in, OFF_REQ2);
    wr_tx_data = bus_in.wr & hit(bus_in, OFF_TX_DATA);
    rd_rx_data = bus_in.rd & hit(bus_in, OFF_RX_DATA);
  end

  // enable registers, plain read/write
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      enable0_r <= RESET_EN;
      enable1_r <= RESET_EN;
      enable2_r <= RESET_EN;
    end else begin
      if (bus_in.wr && hit(bus_in, OFF_EN0)) begin
        enable0_r <= bus_in.wdata & IMPL_MASK_0;
      end
      if (bus_in.wr && hit(bus_in, OFF_EN1)) begin
        enable1_r <= bus_in.wdata & IMPL_MASK_1;
      end
      if (bus_in.wr && hit(bus_in, OFF_EN2)) begin
        enable2_r <= bus_in.wdata & IMPL_MASK_2;
      end
    end
  end

  // edge history for PWM trailing edges and the timer gate
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pwm1_prev_r <= 1'b0;
      pwm2_prev_r <= 1'b0;
      gate_prev_r <= 1'b0;
    end else begin
      pwm1_prev_r <= ccp1_in.pwm_level;
      pwm2_prev_r <= ccp2_in.pwm_level;
      gate_prev_r <= timer1_gate_active_in;
    end
  end

  // set terms take no account of any enable or gate
  always_comb begin
    capcmp1_set = ccp_event(ccp1_in, pwm1_prev_r); // R1 R14
    capcmp2_set = ccp_event(ccp2_in, pwm2_prev_r); // R2 R14
    gate_set = gate_prev_r & ~timer1_gate_active_in; // R13 R14
    set0 = 8'h00;
    set0[BIT_TIMER0] = evt_in.timer0;
    set0[BIT_EXT_PIN] = evt_in.ext_pin;
    set1 = 8'h00;
    set1[BIT_CAPCMP1] = capcmp1_set; // R1
    set1[BIT_TIMER2] = evt_in.timer2; // R3
    set1[BIT_TIMER1] = evt_in.timer1; // R4
    set1[BIT_BUS_COLL] = evt_in.bus_collision; // R9
    set1[BIT_SYNC_SER] = evt_in.sync_serial; // R10
    set1[BIT_CONVERTER] = evt_in.converter; // R11
    set2 = 8'h00;
    set2[BIT_CAPCMP2] = capcmp2_set; // R2
    set2[BIT_NVM_DONE] = evt_in.nvm_done; // R12
    set2[BIT_T1_GATE] = gate_set; // R13
  end

  // sticky flags: hardware sets, software write of 0 clears
  pifeb_flag_reg #(
    .STICKY(STICKY_MASK_0)
  ) u_req0 (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .set_in(set0),
    .wr_in(wr_req0),
    .wdata_in(bus_in.wdata),
    .flags_out(sticky0)
  );

  pifeb_flag_reg #(
    .STICKY(STICKY_MASK_1)
  ) u_req1 ( // R3 R4 R9 R10 R11
    .clock_in(clock_in),
    .reset_in(reset_in),
    .set_in(set1),
    .wr_in(wr_req1),
    .wdata_in(bus_in.wdata),
    .flags_out(sticky1)
  );

  pifeb_flag_reg #(
    .STICKY(STICKY_MASK_2)
  ) u_req2 ( // R2 R12 R13
    .clock_in(clock_in),
    .reset_in(reset_in),
    .set_in(set2),
    .wr_in(wr_req2),
    .wdata_in(bus_in.wdata),
    .flags_out(sticky2)
  );

  // the buffer status lags one cycle behind a pop or load, so the flag is
  // masked for that cycle rather than showing a stale buffer state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rx_pop_hold_r <= 1'b0;
      tx_load_hold_r <= 1'b0;
    end else begin
      rx_pop_hold_r <= rd_rx_data; // R6
      tx_load_hold_r <= wr_tx_data; // R8
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      tx_data_r <= 8'h00;
    end else if (wr_tx_data) begin
      tx_data_r <= bus_in.wdata;
    end
  end

  always_comb begin
    serial_rx_flag = uart_in.rx_not_empty & ~rx_pop_hold_r; // R5 R6
    serial_tx_flag = uart_in.tx_buf_empty & ~tx_load_hold_r; // R7 R8
    change_detect_flag = |pin_change_flags_in; // R18
  end

  // assembled request registers
  always_comb begin
    request0 = sticky0;
    request0[BIT_CHANGE] = change_detect_flag; // R18
    request1 = sticky1;
    request1[BIT_SERIAL_RX] = serial_rx_flag; // R5
    request1[BIT_SERIAL_TX] = serial_tx_flag; // R7
    request2 = sticky2;
  end

  // pending terms and gating toward the core
  always_comb begin
    pend0 = request0 & enable0_r; // R19
    pend1 = request1 & enable1_r; // R19
    pend2 = request2 & enable2_r; // R19
    any_pend0 = |pend0;
    any_pend12 = |{pend1, pend2};
    irq_nxt = global_irq_gate_in & (any_pend0 | (periph_irq_gate_in & any_pend12)); // R16 R17 R19
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // read path, data one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rd_data_nxt = READ_ZERO;
    case (1'b1)
      hit(bus_in, OFF_REQ0): rd_data_nxt = request0;
      hit(bus_in, OFF_REQ1): rd_data_nxt = request1;
      hit(bus_in, OFF_REQ2): rd_data_nxt = request2;
      hit(bus_in, OFF_EN0): rd_data_nxt = enable0_r;
      hit(bus_in, OFF_EN1): rd_data_nxt = enable1_r;
      hit(bus_in, OFF_EN2): rd_data_nxt = enable2_r;
      hit(bus_in, OFF_RX_DATA): rd_data_nxt = uart_in.rx_data;
      hit(bus_in, OFF_TX_DATA): rd_data_nxt = tx_data_r;
      hit(bus_in, OFF_STATUS): begin
        rd_data_nxt[BIT_ST_IRQ] = irq_r;
        rd_data_nxt[BIT_ST_PEND0] = any_pend0;
        rd_data_nxt[BIT_ST_PEND12] = any_pend12;
        rd_data_nxt[BIT_ST_SHIFT_EMPTY] = uart_in.tx_shift_empty; // R8
      end
      default: rd_data_nxt = READ_ZERO;
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      rd_data_r <= READ_ZERO;
    end else if (bus_in.rd) begin
      rd_data_r <= rd_data_nxt;
    end else begin
      rd_data_r <= READ_ZERO;
    end
  end

  assign rd_data_out = rd_data_r;
  assign rx_pop_out = rd_rx_data; // R6
  assign tx_load_out = wr_tx_data; // R8
  assign tx_data_out = tx_data_r;
  assign irq_out = irq_r;
  assign pending0_out = pend0;
  assign pending1_out = pend1;
  assign pending2_out = pend2;

endmodule : pifeb_bank

/* pifeb_uart_model.sv */
`timescale 1ns/100ps
module pifeb_uart_model (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic push_in,
  input wire logic [7:0] byte_in,
  input wire logic rx_pop_in,
  input wire logic tx_load_in,
  output pifeb_pkg::pifeb_uart_t uart_out
);
  import pifeb_pkg::*;
  logic full_r;
  logic [7:0] data_r;
  logic [3:0] tx_cnt_r;
  // an emptied buffer shows the inverted byte, so a stale copy never passes
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      full_r <= 1'b0;
      data_r <= 8'h00;
    end else if (push_in) begin
      full_r <= 1'b1;
      data_r <= byte_in;
    end else if (rx_pop_in) begin
      full_r <= 1'b0;
      data_r <= ~data_r;
    end
  end
  always_ff @(posedge clock_in) begin
    if (reset_in) tx_cnt_r <= 4'h0;
    else if (tx_load_in) tx_cnt_r <= 4'hf;
    else if (tx_cnt_r != 4'h0) tx_cnt_r <= tx_cnt_r - 4'h1;
  end
  // buffer frees well before the shift register drains
  assign uart_out = '{full_r, tx_cnt_r < 4'hc, tx_cnt_r == 4'h0, data_r};
endmodule : pifeb_uart_model

/* pifeb_bank_properties.sv */
`timescale 1ns/100ps
module pifeb_bank_chk (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire pifeb_pkg::pifeb_bus_t bus_in,
  input wire logic [7:0] rd_data_out,
  input wire pifeb_pkg::pifeb_evt_t evt_in,
  input wire logic [23:0] pin_change_flags_in,
  input wire pifeb_pkg::pifeb_uart_t uart_in,
  input wire logic rx_pop_out,
  input wire logic tx_load_out,
  input wire logic global_irq_gate_in,
  input wire logic periph_irq_gate_in,
  input wire logic irq_out,
  input wire logic [7:0] pending0_out,
  input wire logic [7:0] pending1_out,
  input wire logic [7:0] pending2_out
);
  import pifeb_pkg::*;
  logic want_irq;
  logic req1_wr;
  assign want_irq = global_irq_gate_in && ((|pending0_out) || (periph_irq_gate_in && (|{pending1_out, pending2_out})));
  assign req1_wr = bus_in.wr && (bus_in.addr == OFF_REQ1 || bus_in.addr == OFF_EN1);
  default clocking @(posedge clock_in); endclocking
  default disable iff (reset_in);
  sequence s_rx_read; bus_in.rd && bus_in.addr == OFF_RX_DATA; endsequence
  sequence s_tx_write; bus_in.wr && bus_in.addr == OFF_TX_DATA; endsequence
  property p_rx_pop; rx_pop_out == (bus_in.rd && bus_in.addr == OFF_RX_DATA); endproperty
  property p_tx_load; tx_load_out == (bus_in.wr && bus_in.addr == OFF_TX_DATA); endproperty
  property p_rx_data; s_rx_read |=> rd_data_out == $past(uart_in.rx_data); endproperty
  property p_tx_pend; s_tx_write |=> !pending1_out[BIT_SERIAL_TX]; endproperty
  property p_irq; irq_out == $past(want_irq); endproperty
  property p_no_global; !global_irq_gate_in |=> !irq_out; endproperty
  property p_t1_stick; pending1_out[BIT_TIMER1] && !req1_wr |=> pending1_out[BIT_TIMER1]; endproperty
  property p_t1_set; $rose(pending1_out[BIT_TIMER1]) |-> $past(evt_in.timer1) || $past(bus_in.wr); endproperty
  property p_chg; pending0_out[BIT_CHANGE] |-> |pin_change_flags_in; endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("rx pop wrong");
  a_tx_load: assert property (p_tx_load) else $error("tx load wrong");
  a_rx_data: assert property (p_rx_data) else $error("rx data read wrong");
  a_tx_pend: assert property (p_tx_pend) else $error("tx pending right after a load");
  a_irq: assert property (p_irq) else $error("irq gating wrong");
  a_no_global: assert property (p_no_global) else $error("irq without global gate");
  a_t1_stick: assert property (p_t1_stick) else $error("timer1 flag dropped");
  a_t1_set: assert property (p_t1_set) else $error("timer1 flag set without cause");
  a_chg: assert property (p_chg) else $error("change flag without pin flags");
endmodule : pifeb_bank_chk
bind pifeb_bank pifeb_bank_chk i_pifeb_bank_chk (.clock_in(clock_in), .reset_in(reset_in), .bus_in(bus_in),
  .rd_data_out(rd_data_out), .evt_in(evt_in), .pin_change_flags_in(pin_change_flags_in), .uart_in(uart_in),
  .rx_pop_out(rx_pop_out), .tx_load_out(tx_load_out), .global_irq_gate_in(global_irq_gate_in),
  .periph_irq_gate_in(periph_irq_gate_in), .irq_out(irq_out), .pending0_out(pending0_out),
  .pending1_out(pending1_out), .pending2_out(pending2_out));

/* test_pifeb_bank.sv */
`timescale 1ns/100ps
module test_pifeb_bank;
  import pifeb_pkg::*;
  logic clock_in, reset_in, rx_pop, tx_load, g_gate, p_gate, irq, gate_act, push;
  logic [7:0] rd_data, tx_data, pend0, pend1, pend2, rx_byte;
  logic [23:0] pin_chg;
  pifeb_bus_t bus;
  pifeb_ccp_t ccp1, ccp2;
  pifeb_evt_t evt;
  pifeb_uart_t uart;
  int error_cnt = 0;
  int n_compared = 0;
  pifeb_bank i_pifeb_bank (.clock_in(clock_in), .reset_in(reset_in), .bus_in(bus), .rd_data_out(rd_data),
    .ccp1_in(ccp1), .ccp2_in(ccp2), .evt_in(evt), .timer1_gate_active_in(gate_act), .pin_change_flags_in(pin_chg),
    .uart_in(uart), .rx_pop_out(rx_pop), .tx_load_out(tx_load), .tx_data_out(tx_data), .global_irq_gate_in(g_gate),
    .periph_irq_gate_in(p_gate), .irq_out(irq), .pending0_out(pend0), .pending1_out(pend1), .pending2_out(pend2));
  pifeb_uart_model i_pifeb_uart_model (.clock_in(clock_in), .reset_in(reset_in), .push_in(push), .byte_in(rx_byte),
    .rx_pop_in(rx_pop), .tx_load_in(tx_load), .uart_out(uart));
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus <= {a, d, 2'b10};
    @(posedge clock_in);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock_in);
    bus <= {a, 8'h00, 2'b01};
    @(posedge clock_in);
    bus.rd <= 1'b0;
    @(negedge clock_in);
    chk(rd_data, e);
  endtask : rd
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clock_in);
    chk({7'h00, irq}, {7'h00, e});
  endtask : irq_is
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // far more than the sequence needs, so only a hang reaches it
  initial begin
    #20000;
    error_cnt++;
    close_out();
  end
  initial begin
    reset_in = 1'b1;
    bus = '0;
    ccp1 = {CCP_OFF, 3'b000};
    ccp2 = {CCP_OFF, 3'b000};
    evt = '0;
    {gate_act, g_gate, p_gate, push, rx_byte, pin_chg} = '0;
    repeat (5) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(OFF_REQ1, 8'h08);
    rd(OFF_EN1, RESET_EN);
    rd(12'h700, READ_ZERO);
    @(posedge clock_in);
    evt <= 8'hff;
    pin_chg <= 24'h000100;
    gate_act <= 1'b1;
    ccp1 <= {CCP_CAPTURE, 3'b100};
    ccp2 <= {CCP_PWM, 3'b001};
    @(posedge clock_in);
    evt <= '0;
    gate_act <= 1'b0;
    ccp1 <= {CCP_CAPTURE, 3'b000};
    ccp2 <= {CCP_PWM, 3'b000};
    repeat (3) @(posedge clock_in);
    rd(OFF_REQ0, 8'h31);
    rd(OFF_REQ1, 8'hef);
    rd(OFF_REQ2, 8'he0);
    @(posedge clock_in);
    pin_chg <= '0;
    wr(OFF_REQ0, 8'h00);
    wr(OFF_REQ1, 8'h00);
    wr(OFF_REQ2, 8'h00);
    rd(OFF_REQ0, 8'h00);
    rd(OFF_REQ1, 8'h08);
    rd(OFF_REQ2, 8'h00);
    @(posedge clock_in);
    ccp1 <= {CCP_COMPARE, 3'b010};
    ccp2 <= {CCP_OFF, 3'b110};
    @(posedge clock_in);
    ccp1 <= {CCP_COMPARE, 3'b000};
    ccp2 <= {CCP_OFF, 3'b000};
    rd(OFF_REQ1, 8'h88);
    rd(OFF_REQ2, 8'h00);
    wr(OFF_REQ1, 8'h00);
    @(posedge clock_in);
    push <= 1'b1;
    rx_byte <= 8'ha5;
    @(posedge clock_in);
    push <= 1'b0;
    wr(OFF_REQ1, 8'h00);
    rd(OFF_REQ1, 8'h18);
    rd(OFF_RX_DATA, 8'ha5);
    rd(OFF_REQ1, 8'h08);
    wr(OFF_TX_DATA, 8'h3c);
    rd(OFF_REQ1, 8'h00);
    chk(tx_data, 8'h3c);
    rd(OFF_STATUS, 8'h00);
    repeat (20) @(posedge clock_in);
    rd(OFF_REQ1, 8'h08);
    rd(OFF_STATUS, 8'h08);
    @(posedge clock_in);
    evt <= 8'h10;
    g_gate <= 1'b1;
    @(posedge clock_in);
    evt <= '0;
    wr(OFF_EN1, 8'h28);
    rd(OFF_EN1, 8'h28);
    chk(pend1, 8'h28);
    irq_is(1'b0);
    @(posedge clock_in);
    p_gate <= 1'b1;
    irq_is(1'b1);
    wr(OFF_REQ1, 8'h00);
    irq_is(1'b1);
    chk(pend1, 8'h08);
    wr(OFF_EN1, 8'h00);
    irq_is(1'b0);
    @(posedge clock_in);
    p_gate <= 1'b0;
    evt <= 8'h40;
    pin_chg <= 24'h800000;
    @(posedge clock_in);
    evt <= '0;
    wr(OFF_EN0, 8'h11);
    irq_is(1'b1);
    chk(pend0, 8'h11);
    @(posedge clock_in);
    g_gate <= 1'b0;
    irq_is(1'b0);
    wr(OFF_EN1, 8'h08);
    @(negedge clock_in);
    chk(pend1, 8'h08);
    wr(OFF_TX_DATA, 8'h5a);
    @(negedge clock_in);
    chk(pend1, 8'h00);
    // mid-run reset clears sticky flags and enables, not the pin-driven bits
    @(posedge clock_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(OFF_REQ0, 8'h10);
    rd(OFF_REQ1, 8'h08);
    rd(OFF_TX_DATA, 8'h00);
    wr(OFF_REQ2, 8'h00);
    wr(OFF_EN2, 8'h80);
    ccp2 <= {CCP_COMPARE, 3'b010};
    g_gate <= 1'b1;
    p_gate <= 1'b1;
    @(posedge clock_in);
    ccp2 <= {CCP_COMPARE, 3'b000};
    irq_is(1'b1);
    chk(pend2, 8'h80);
    rd(OFF_STATUS, 8'h0d);
    @(posedge clock_in);
    p_gate <= 1'b0;
    irq_is(1'b0);
    close_out();
  end
endmodule : test_pifeb_bank
